// *** src/boot_cmd_pkg.sv ***
package boot_cmd_pkg;

	// command codes carried in the first packet byte
	localparam logic [7:0] CMD_VERSION = 8'h00;
	localparam logic [7:0] CMD_PROG_READ = 8'h01;
	localparam logic [7:0] CMD_PROG_WRITE = 8'h02;
	localparam logic [7:0] CMD_PROG_ERASE = 8'h03;
	localparam logic [7:0] CMD_DATA_READ = 8'h04;
	localparam logic [7:0] CMD_DATA_WRITE = 8'h05;
	localparam logic [7:0] CMD_CFG_READ = 8'h06;
	localparam logic [7:0] CMD_CFG_WRITE = 8'h07;

	// fixed field values
	localparam logic [7:0] VERSION_LEN = 8'h02;
	localparam logic [7:0] BOOT_FLAG_VAL = 8'hff;
	localparam logic [7:0] ZERO_LEN = 8'h00;
	localparam logic [15:0] RESET_VECTOR = 16'h0000;

	// buffer layout
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_LEN = 8'h01;
	localparam logic [7:0] OFS_ADDRL = 8'h02;
	localparam logic [7:0] OFS_ADDRH = 8'h03;
	localparam logic [7:0] OFS_ADDRU = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h05;
	localparam logic [8:0] HDR_LEN = 9'h005;
	localparam logic [8:0] MIN_RESET_LEN = 9'h002;
	localparam logic [8:0] VER_LAST_IDX = 9'h003;
	localparam logic [8:0] ACK_LAST_IDX = 9'h000;
	localparam logic [8:0] VERL_IDX = 9'h002;
	localparam logic [8:0] VERH_IDX = 9'h003;

	// memory unit sizes
	localparam logic [10:0] BLOCK_BYTES = 11'h008;
	localparam logic [6:0] ROW_BYTES = 7'h40;
	localparam logic [6:0] STEP_BYTE = 7'h01;
	localparam logic [10:0] ONE_LEFT = 11'h001;

	typedef enum logic [1:0] {SPACE_PROG = 2'b00, SPACE_DATA = 2'b01, SPACE_CFG = 2'b10} mem_space_t;
	typedef enum logic [1:0] {OP_READ = 2'b00, OP_WRITE = 2'b01, OP_ERASE = 2'b10} mem_op_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_REQ = 2'b01, ST_WAIT = 2'b10, ST_SEND = 2'b11} state_t;

	// one memory access handed to the programming sequencers
	typedef struct packed {
		mem_space_t space;
		mem_op_t op;
		logic [23:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	// decoded command
	typedef struct packed {
		logic legal;
		logic is_version;
		mem_space_t space;
		mem_op_t op;
		logic [10:0] total;
		logic [6:0] step;
	} cmd_info_t;

endpackage

// *** src/cmd_decode.sv ***
`timescale 1ns/10ps
module cmd_decode
	import boot_cmd_pkg::*;
#(
	parameter bit FULL_VARIANT = 1'b1
)
(
	input wire logic [7:0] cmd_i,
	input wire logic [7:0] len_i,
	output cmd_info_t info_o
);

	// map command code and length onto access kind and unit counts
	always_comb
	begin
		info_o = '0;
		info_o.total = {3'h0, len_i};
		info_o.step = STEP_BYTE;
		case (cmd_i)
			CMD_VERSION:
			begin
				info_o.legal = (len_i == VERSION_LEN);
				info_o.is_version = 1'b1;
			end
			CMD_PROG_READ:
			begin
				info_o.legal = 1'b1;
				info_o.space = SPACE_PROG;
				info_o.op = OP_READ;
			end
			CMD_PROG_WRITE:
			begin
				info_o.legal = 1'b1;
				info_o.space = SPACE_PROG;
				info_o.op = OP_WRITE;
				info_o.total = {3'h0, len_i} * BLOCK_BYTES;
			end
			CMD_PROG_ERASE:
			begin
				info_o.legal = FULL_VARIANT;
				info_o.space = SPACE_PROG;
				info_o.op = OP_ERASE;
				info_o.step = ROW_BYTES;
			end
			CMD_DATA_READ:
			begin
				info_o.legal = 1'b1;
				info_o.space = SPACE_DATA;
				info_o.op = OP_READ;
			end
			CMD_DATA_WRITE:
			begin
				info_o.legal = 1'b1;
				info_o.space = SPACE_DATA;
				info_o.op = OP_WRITE;
			end
			CMD_CFG_READ:
			begin
				info_o.legal = FULL_VARIANT;
				info_o.space = SPACE_CFG;
				info_o.op = OP_READ;
			end
			CMD_CFG_WRITE:
			begin
				info_o.legal = FULL_VARIANT;
				info_o.space = SPACE_CFG;
				info_o.op = OP_WRITE;
			end
			default:
			begin
				info_o.legal = 1'b0;
			end
		endcase
	end

endmodule

// *** src/mem_access.sv ***
`timescale 1ns/10ps
module mem_access
	import boot_cmd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic start_i,
	input mem_req_t req_i,
	output logic done_o,
	output logic [7:0] rdata_o,
	output logic mem_valid_o,
	output mem_req_t mem_req_o,
	input wire logic mem_done_i,
	input wire logic [7:0] mem_rdata_i
);

	logic busy_q, busy_d;
	mem_req_t req_q, req_d;
	logic [7:0] rdata_q, rdata_d;
	logic done_q, done_d;

	// hold one request until the sequencer reports completion
	always_comb
	begin
		busy_d = busy_q;
		req_d = req_q;
		rdata_d = rdata_q;
		done_d = 1'b0;
		if (start_i && !busy_q)
		begin
			busy_d = 1'b1;
			req_d = req_i;
		end
		else if (busy_q && mem_done_i)
		begin
			busy_d = 1'b0;
			rdata_d = mem_rdata_i;
			done_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			busy_q <= 1'b0;
			req_q <= '0;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
		end
		else
		begin
			busy_q <= busy_d;
			req_q <= req_d;
			rdata_q <= rdata_d;
			done_q <= done_d;
		end
	end

	assign mem_valid_o = busy_q;
	assign mem_req_o = req_q;
	assign done_o = done_q;
	assign rdata_o = rdata_q;

endmodule

// *** src/boot_command_interpreter.sv ***
// Summary of operation
// - version command 00h,02h replies those two bytes plus version low then high
// - program read echoes five header bytes then length bytes from program memory
// - program write stores the given blocks, replies with the command byte only
// - full variant erases the given rows, replies with the command byte only
// - data read echoes the header then length bytes of data memory
// - data write stores length bytes, replies with the command byte only
// - full variant config read echoes the header then length config bytes
// - full variant config write stores length bytes, replies with command byte
// - empty packet reruns the command left in the buffer, same reply
// - write header without data writes the old buffered data at the new address
// - zero length means reset, no reply; reduced variant jumps to 0000h
// - reduced variant refuses erase, config read and config write
// - last data location FFh means boot mode, anything else user mode
// - one program write block is eight bytes
`timescale 1ns/10ps
module boot_command_interpreter
	import boot_cmd_pkg::*;
#(
	parameter bit FULL_VARIANT = 1'b1,
	parameter logic [15:0] VERSION = 16'h0102,
	parameter int BUF_DEPTH = 256
)
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	input wire logic rx_end_i,
	output logic rx_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	output logic tx_last_o,
	input wire logic tx_ready_i,
	output logic mem_valid_o,
	output mem_req_t mem_req_o,
	input wire logic mem_done_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic [7:0] boot_flag_i,
	output logic boot_mode_o,
	output logic sys_reset_req_o,
	output logic jump_req_o,
	output logic [15:0] jump_addr_o
);

	logic [7:0] buf_mem [BUF_DEPTH];
	state_t state_q, state_d;
	logic [8:0] rx_cnt_q, rx_cnt_d;
	cmd_info_t info_q, info_d, info_dec;
	logic [7:0] cmd_q, cmd_d;
	logic [23:0] addr_q, addr_d;
	logic [10:0] cnt_q, cnt_d;
	logic [7:0] bidx_q, bidx_d;
	logic [8:0] tx_idx_q, tx_idx_d;
	logic [8:0] tx_last_idx_q, tx_last_idx_d;
	logic [7:0] tx_data_q, tx_data_d;
	logic boot_mode_q, boot_mode_d;
	logic sys_reset_q, sys_reset_d;
	logic jump_q, jump_d;
	logic buf_we;
	logic [7:0] buf_wa;
	logic [7:0] buf_wd;
	logic start_mem;
	logic mem_done;
	logic [7:0] mem_rdata;
	logic exec_start;
	logic tx_fire;
	mem_req_t req_new;

	// byte placed on the reply stream for a given reply position
	function automatic logic [7:0] reply_byte(input logic [8:0] idx, input logic is_ver, input logic [7:0] stored);
		logic [7:0] b;
		b = stored;
		if (is_ver && idx == VERL_IDX)
			b = VERSION[7:0];
		else if (is_ver && idx == VERH_IDX)
			b = VERSION[15:8];
		return b;
	endfunction

	// decode header bytes still held in the buffer
	cmd_decode #(
		.FULL_VARIANT(FULL_VARIANT)
	) u_decode (
		.cmd_i(buf_mem[OFS_CMD]),
		.len_i(buf_mem[OFS_LEN]),
		.info_o(info_dec)
	);

	// one request at a time toward the sequencers
	mem_access u_mem (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.start_i(start_mem),
		.req_i(req_new),
		.done_o(mem_done),
		.rdata_o(mem_rdata),
		.mem_valid_o(mem_valid_o),
		.mem_req_o(mem_req_o),
		.mem_done_i(mem_done_i),
		.mem_rdata_i(mem_rdata_i)
	);

	assign tx_fire = (state_q == ST_SEND) && tx_ready_i;
	assign req_new = '{space: info_q.space, op: info_q.op, addr: addr_q, wdata: buf_mem[bidx_q]};

	// command sequencing: receive, execute one byte or one erase row at a time, then reply
	always_comb
	begin
		state_d = state_q;
		rx_cnt_d = rx_cnt_q;
		info_d = info_q;
		cmd_d = cmd_q;
		addr_d = addr_q;
		cnt_d = cnt_q;
		bidx_d = bidx_q;
		tx_idx_d = tx_idx_q;
		tx_last_idx_d = tx_last_idx_q;
		tx_data_d = tx_data_q;
		boot_mode_d = (boot_flag_i == BOOT_FLAG_VAL);
		sys_reset_d = 1'b0;
		jump_d = 1'b0;
		buf_we = 1'b0;
		buf_wa = rx_cnt_q[7:0];
		buf_wd = rx_data_i;
		start_mem = 1'b0;
		exec_start = 1'b0;
		case (state_q)
			ST_IDLE:
			begin
				if (boot_mode_q && rx_valid_i)
				begin
					buf_we = 1'b1;
					rx_cnt_d = rx_cnt_q + 9'h001;
				end
				else if (boot_mode_q && rx_end_i)
				begin
					rx_cnt_d = '0;
					if (rx_cnt_q >= MIN_RESET_LEN && buf_mem[OFS_LEN] == ZERO_LEN)
					begin
						sys_reset_d = FULL_VARIANT;
						jump_d = !FULL_VARIANT;
					end
					// an empty packet reaches here too and replays the held header
					// a bare write header keeps the old data from the data offset on
					else if ((rx_cnt_q == '0 || rx_cnt_q >= MIN_RESET_LEN) && info_dec.legal)
					begin
						exec_start = 1'b1;
						info_d = info_dec;
						cmd_d = buf_mem[OFS_CMD];
						addr_d = {buf_mem[OFS_ADDRU], buf_mem[OFS_ADDRH], buf_mem[OFS_ADDRL]};
						cnt_d = info_dec.total;
						bidx_d = OFS_DATA;
						tx_idx_d = '0;
						tx_data_d = buf_mem[OFS_CMD];
						if (info_dec.is_version)
						begin
							tx_last_idx_d = VER_LAST_IDX;
							state_d = ST_SEND;
						end
						else
						begin
							state_d = ST_REQ;
						end
					end
				end
			end
			ST_REQ:
			begin
				start_mem = 1'b1;
				state_d = ST_WAIT;
			end
			ST_WAIT:
			begin
				if (mem_done)
				begin
					if (info_q.op == OP_READ)
					begin
						buf_we = 1'b1; // read data overwrites the buffer behind the header
						buf_wa = bidx_q;
						buf_wd = mem_rdata;
					end
					addr_d = addr_q + {17'h00000, info_q.step};
					bidx_d = bidx_q + 8'h01;
					cnt_d = cnt_q - ONE_LEFT;
					if (cnt_q == ONE_LEFT)
					begin
						state_d = ST_SEND;
						if (info_q.op == OP_READ)
							tx_last_idx_d = 9'(HDR_LEN + info_q.total - ONE_LEFT);
						else
							tx_last_idx_d = ACK_LAST_IDX;
					end
					else
					begin
						state_d = ST_REQ;
					end
				end
			end
			ST_SEND:
			begin
				if (tx_fire)
				begin
					tx_idx_d = tx_idx_q + 9'h001;
					tx_data_d = reply_byte(tx_idx_q + 9'h001, info_q.is_version, buf_mem[tx_idx_q[7:0] + 8'h01]);
					if (tx_idx_q == tx_last_idx_q)
						state_d = ST_IDLE;
				end
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// control registers
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_q <= ST_IDLE;
			rx_cnt_q <= '0;
			info_q <= '0;
			cmd_q <= 8'h00;
			addr_q <= 24'h000000;
			cnt_q <= '0;
			bidx_q <= 8'h00;
			tx_idx_q <= '0;
			tx_last_idx_q <= '0;
			tx_data_q <= 8'h00;
			boot_mode_q <= 1'b0;
			sys_reset_q <= 1'b0;
			jump_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			rx_cnt_q <= rx_cnt_d;
			info_q <= info_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			cnt_q <= cnt_d;
			bidx_q <= bidx_d;
			tx_idx_q <= tx_idx_d;
			tx_last_idx_q <= tx_last_idx_d;
			tx_data_q <= tx_data_d;
			boot_mode_q <= boot_mode_d;
			sys_reset_q <= sys_reset_d;
			jump_q <= jump_d;
		end
	end

	// packet buffer keeps its contents between packets
	always_ff @(posedge sys_clk_i)
	begin
		if (buf_we)
			buf_mem[buf_wa] <= buf_wd;
	end

	assign rx_ready_o = (state_q == ST_IDLE) && boot_mode_q;
	assign tx_valid_o = (state_q == ST_SEND);
	assign tx_data_o = tx_data_q;
	assign tx_last_o = (state_q == ST_SEND) && (tx_idx_q == tx_last_idx_q);
	assign boot_mode_o = boot_mode_q;
	assign sys_reset_req_o = sys_reset_q;
	assign jump_req_o = jump_q;
	assign jump_addr_o = RESET_VECTOR;

	// checks
	sequence last_access_done_s;
		(state_q == ST_WAIT) && mem_done && (cnt_q == ONE_LEFT);
	endsequence

	sequence reply_open_s;
		(state_q == ST_SEND) && (tx_idx_q == '0);
	endsequence

	ver_reply_low_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(state_q == ST_SEND && info_q.is_version && tx_idx_q == VERL_IDX) |-> tx_data_o == VERSION[7:0])
		else $error("version low byte wrong");

	echo_first_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		reply_open_s |-> tx_data_o == cmd_q)
		else $error("reply does not open with command byte");

	read_length_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(state_q == ST_SEND && info_q.op == OP_READ && !info_q.is_version)
		|-> tx_last_idx_q == 9'(HDR_LEN + info_q.total - ONE_LEFT))
		else $error("read reply length wrong");

	write_ack_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(state_q == ST_SEND && info_q.op != OP_READ && !info_q.is_version) |-> tx_last_o)
		else $error("write reply is more than one byte");

	erase_step_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(state_q == ST_WAIT && mem_done && info_q.op == OP_ERASE) |=> addr_q == $past(addr_q) + 24'(ROW_BYTES))
		else $error("erase address not advanced by a row");

	reply_after_done_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		last_access_done_s |=> reply_open_s and !mem_valid_o)
		else $error("reply not started right after last access");

	reset_silent_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(sys_reset_req_o || jump_req_o) |-> !tx_valid_o ##1 !tx_valid_o ##1 !tx_valid_o)
		else $error("reset request produced a reply");

	reduced_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		!FULL_VARIANT |-> !(mem_valid_o && (mem_req_o.space == SPACE_CFG || mem_req_o.op == OP_ERASE)))
		else $error("reduced variant issued a refused access");

	user_mode_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		($past(boot_flag_i) != BOOT_FLAG_VAL) |-> !rx_ready_o)
		else $error("packet accepted outside boot mode");

	block_count_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
		(exec_start && info_dec.op == OP_WRITE && info_dec.space == SPACE_PROG)
		|=> cnt_q == {3'h0, buf_mem[OFS_LEN]} * BLOCK_BYTES)
		else $error("program write byte count not eight per block");

endmodule

// *** verif/mem_seq_model.sv ***
`timescale 1ns/10ps
// behavioural programming sequencer: one request at a time, answered after a short or a long wait
module mem_seq_model
	import boot_cmd_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic slow_i,
	input wire logic mem_valid_i,
	input wire mem_req_t mem_req_i,
	output logic mem_done_o,
	output logic [7:0] mem_rdata_o,
	output int req_cnt_o,
	output mem_req_t last_req_o
);
	logic busy_q;
	int wait_q;

	// done lasts one cycle; read data toggles outside it so a stale byte is never reused
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			busy_q <= 1'b0;
			wait_q <= 0;
			mem_done_o <= 1'b0;
			mem_rdata_o <= 8'h00;
			req_cnt_o <= 0;
			last_req_o <= '0;
		end
		else
		begin
			mem_done_o <= 1'b0;
			mem_rdata_o <= ~mem_rdata_o;
			if (busy_q && wait_q == 0)
			begin
				mem_done_o <= 1'b1;
				mem_rdata_o <= mem_req_i.addr[7:0] ^ {6'h00, mem_req_i.space} ^ 8'h3c;
				busy_q <= 1'b0;
				req_cnt_o <= req_cnt_o + 1;
				last_req_o <= mem_req_i;
			end
			else if (busy_q)
				wait_q <= wait_q - 1;
			else if (mem_valid_i && !mem_done_o)
			begin
				busy_q <= 1'b1;
				wait_q <= slow_i ? 4 : 0;
			end
		end
	end
endmodule

// *** verif/boot_command_interpreter_test.sv ***
`timescale 1ns/10ps
module boot_command_interpreter_test
	import boot_cmd_pkg::*;
;
	localparam logic [15:0] VER = 16'h5a3c; // arbitrary version value
	logic sys_clk_i, resetn_i, rx_valid_i, rx_end_i, rx_ready_o, tx_valid_o, tx_last_o, tx_ready_i;
	logic mem_valid_o, mem_done_i, boot_mode_o, sys_reset_req_o, jump_req_o, slow;
	logic red_tx_valid, red_mem_valid, red_mem_done, red_sys_reset, red_jump;
	logic [7:0] red_mem_rdata, len_r;
	logic [15:0] red_jump_addr;
	logic [23:0] adr_r;
	mem_req_t red_mem_req;
	int red_req_cnt;
	int red_tx_cnt = 0;
	int jmp_cnt = 0;
	int alt_cnt = 0;
	logic [7:0] rx_data_i, tx_data_o, mem_rdata_i, boot_flag_i;
	logic [15:0] jump_addr_o;
	logic [7:0] dq[$];
	mem_req_t mem_req_o, last_req;
	int req_cnt, error_cnt, tests_run, seed, i, c;
	int rst_cnt = 0;
	int txv_cnt = 0;

	boot_command_interpreter #(.FULL_VARIANT(1'b1), .VERSION(VER), .BUF_DEPTH(256)) uut (.sys_clk_i, .resetn_i,
		.rx_valid_i, .rx_data_i, .rx_end_i, .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i,
		.mem_valid_o, .mem_req_o, .mem_done_i, .mem_rdata_i, .boot_flag_i, .boot_mode_o, .sys_reset_req_o,
		.jump_req_o, .jump_addr_o);
	mem_seq_model mem_model (.sys_clk_i, .resetn_i, .slow_i(slow), .mem_valid_i(mem_valid_o),
		.mem_req_i(mem_req_o), .mem_done_o(mem_done_i), .mem_rdata_o(mem_rdata_i), .req_cnt_o(req_cnt),
		.last_req_o(last_req));

	// reduced variant sees the same packets; the host knows which variant it talks to
	boot_command_interpreter #(.FULL_VARIANT(1'b0), .VERSION(VER), .BUF_DEPTH(256)) uut_red (.sys_clk_i, .resetn_i,
		.rx_valid_i, .rx_data_i, .rx_end_i, .rx_ready_o(), .tx_valid_o(red_tx_valid), .tx_data_o(), .tx_last_o(),
		.tx_ready_i, .mem_valid_o(red_mem_valid), .mem_req_o(red_mem_req), .mem_done_i(red_mem_done),
		.mem_rdata_i(red_mem_rdata), .boot_flag_i, .boot_mode_o(), .sys_reset_req_o(red_sys_reset),
		.jump_req_o(red_jump), .jump_addr_o(red_jump_addr));
	mem_seq_model red_model (.sys_clk_i, .resetn_i, .slow_i(slow), .mem_valid_i(red_mem_valid),
		.mem_req_i(red_mem_req), .mem_done_o(red_mem_done), .mem_rdata_o(red_mem_rdata), .req_cnt_o(red_req_cnt),
		.last_req_o());

	initial
	begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	// reply sink stalls at random; counters of reset pulses and reply cycles
	always @(negedge sys_clk_i) tx_ready_i <= ($random(seed) & 3) != 0;
	always @(posedge sys_clk_i)
	begin
		if (sys_reset_req_o === 1'b1) rst_cnt++;
		if (tx_valid_o === 1'b1) txv_cnt++;
		if (red_tx_valid === 1'b1 && tx_ready_i === 1'b1) red_tx_cnt++;
		if (red_jump === 1'b1) jmp_cnt++;
		if (jump_req_o === 1'b1 || red_sys_reset === 1'b1) alt_cnt++;
	end

	task automatic stop_test();
		if (error_cnt == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// write data only matters for write requests
	task automatic cmp_req(input mem_req_t got, input mem_req_t exp);
		tests_run++;
		if (exp.op !== OP_WRITE) exp.wdata = got.wdata;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] rd_pat(input mem_space_t s, input logic [23:0] a);
		return a[7:0] ^ {6'h00, s} ^ 8'h3c;
	endfunction

	task automatic send(input logic [7:0] pkt[$]);
		int n;
		for (n = 0; n < 5000 && rx_ready_o !== 1'b1; n++) @(negedge sys_clk_i);
		if (n == 5000)
		begin
			error_cnt++;
			stop_test();
		end
		foreach (pkt[j])
		begin
			rx_valid_i = 1'b1;
			rx_data_i = pkt[j];
			@(negedge sys_clk_i);
		end
		rx_valid_i = 1'b0;
		rx_end_i = 1'b1;
		@(negedge sys_clk_i);
		rx_end_i = 1'b0;
	endtask

	// collects the reply; by its first byte all memory work must be finished
	task automatic recv(input logic [7:0] exp[$], input int nreq, input int base);
		int n, k;
		k = 0;
		for (n = 0; n < 5000 && k < exp.size(); n++)
		begin
			// look just after the falling edge, where sink ready and the reply have settled
			#1;
			if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1)
			begin
				if (k == 0) cmp_byte(8'(req_cnt - base), 8'(nreq));
				cmp_byte(tx_data_o, exp[k]);
				cmp_byte({7'h00, tx_last_o}, {7'h00, k == exp.size() - 1});
				k++;
			end
			@(negedge sys_clk_i);
		end
		if (k < exp.size())
		begin
			error_cnt++;
			stop_test();
		end
	endtask

	// mode 0 fresh packet, 1 empty repeat packet, 2 write header only
	task automatic run(input logic [7:0] cmd, input logic [7:0] len, input logic [23:0] a, input int mode);
		logic [7:0] pkt[$];
		logic [7:0] exp[$];
		mem_req_t er;
		int tot, base, k, rr, rt;
		mem_space_t sp;
		logic refused;
		sp = cmd < 8'h04 ? SPACE_PROG : (cmd < 8'h06 ? SPACE_DATA : SPACE_CFG);
		tot = (cmd == CMD_PROG_WRITE) ? len * 8 : len;
		er = '{sp, OP_READ, 24'(a + tot - 1), 8'h00};
		pkt = '{cmd, len, a[7:0], a[15:8], a[23:16]};
		exp = '{cmd};
		if (cmd == CMD_PROG_ERASE)
		begin
			er.op = OP_ERASE;
			er.addr = 24'(a + (len - 1) * 64);
		end
		else if (cmd == CMD_PROG_WRITE || cmd == CMD_DATA_WRITE || cmd == CMD_CFG_WRITE)
		begin
			er.op = OP_WRITE;
			if (mode == 0) dq.delete();
			if (mode == 0) repeat (tot) dq.push_back(8'($random(seed)));
			if (mode == 0) pkt = {pkt, dq};
			er.wdata = dq[tot - 1];
		end
		else
		begin
			exp = pkt;
			for (k = 0; k < tot; k++) exp.push_back(rd_pat(sp, 24'(a + k)));
		end
		if (mode == 1) pkt.delete();
		base = req_cnt;
		rr = red_req_cnt;
		rt = red_tx_cnt;
		send(pkt);
		recv(exp, tot, base);
		cmp_req(last_req, er);
		// reduced variant drops erase and config access, answers the rest alike
		refused = (cmd == CMD_PROG_ERASE || cmd == CMD_CFG_READ || cmd == CMD_CFG_WRITE);
		cmp_byte(8'(red_req_cnt - rr), refused ? 8'h00 : 8'(tot));
		cmp_byte(8'(red_tx_cnt - rt), refused ? 8'h00 : 8'(exp.size()));
	endtask

	task automatic quiet(input logic [7:0] pkt[$], input int nrst);
		int r, t, j0, a0, u0;
		r = rst_cnt;
		t = txv_cnt;
		j0 = jmp_cnt;
		a0 = alt_cnt;
		u0 = red_tx_cnt;
		send(pkt);
		repeat (30) @(negedge sys_clk_i);
		cmp_byte(8'(rst_cnt - r), 8'(nrst));
		cmp_byte(8'(txv_cnt - t), 8'h00);
		cmp_byte(8'(jmp_cnt - j0), 8'(nrst));
		cmp_byte(8'(alt_cnt - a0), 8'h00);
		cmp_byte(8'(red_tx_cnt - u0), 8'h00);
		cmp_byte(red_jump_addr[7:0], 8'h00);
		cmp_byte(red_jump_addr[15:8], 8'h00);
		cmp_byte(jump_addr_o[7:0] | jump_addr_o[15:8], 8'h00);
	endtask

	initial
	begin
		{resetn_i, rx_valid_i, rx_end_i, slow} = 4'h0;
		rx_data_i = 8'h00;
		boot_flag_i = BOOT_FLAG_VAL;
		error_cnt = 0;
		tests_run = 0;
		seed = 32'hdb124dff;
		repeat (16) @(negedge sys_clk_i);
		resetn_i = 1'b1;
		@(negedge sys_clk_i);
		send('{8'h00, 8'h02});
		recv('{8'h00, 8'h02, VER[7:0], VER[15:8]}, 0, req_cnt);
		// every memory command 01h to 07h, short and long sequencer waits
		for (c = 1; c < 8; c++)
			for (i = 0; i < 2; i++)
			begin
				slow = i[0];
				len_r = 8'(1 + ($random(seed) & 3));
				if (c == 2) len_r = 8'(2 << ($random(seed) & 1));
				if (c == 7) len_r = 8'h01;
				adr_r = c < 4 ? 24'($random(seed)) : (c < 6 ?
					{8'h00, 16'($random(seed))} : {16'h3000, 8'($random(seed))});
				if (c == 2) adr_r[3:0] = 4'h0;
				run(8'(c), len_r, adr_r, 0);
			end
		run(CMD_DATA_WRITE, 8'h03, 24'h0000fd, 0);
		run(CMD_DATA_WRITE, 8'h03, 24'h0000fd, 1);
		run(CMD_DATA_WRITE, 8'h03, 24'h000140, 2);
		run(CMD_PROG_WRITE, 8'h02, 24'h0003f0, 0);
		run(CMD_PROG_WRITE, 8'h02, 24'h000800, 2);
		run(CMD_DATA_READ, 8'h05, 24'h0000fe, 0);
		run(CMD_DATA_READ, 8'h05, 24'h0000fe, 1);
		quiet('{CMD_CFG_WRITE, ZERO_LEN}, 1);
		quiet('{CMD_VERSION, 8'h03}, 0);
		quiet('{8'h0a, 8'h01, 8'h00, 8'h00, 8'h00}, 0);
		// user mode closes the receiver, boot flag brings it back
		boot_flag_i = 8'h00;
		repeat (3) @(negedge sys_clk_i);
		cmp_byte({7'h00, boot_mode_o}, 8'h00);
		cmp_byte({7'h00, rx_ready_o}, 8'h00);
		boot_flag_i = BOOT_FLAG_VAL;
		repeat (3) @(negedge sys_clk_i);
		cmp_byte({7'h00, boot_mode_o}, 8'h01);
		run(CMD_PROG_ERASE, 8'h01, 24'h00ffc0, 0);
		stop_test();
	end
endmodule
